// [adcc_top.sv]
// Converter control: register file, conversion sequencer and analog pin gating
`timescale 1ns/1ns
`default_nettype none
// How it works
// - One digital input off bit per pin
// - Disabled pins always read as zero
// - Control field layout fixed, resets to zero
// - Start bit starts, reads busy, self-clears
// - Done flag set by hardware, software clears
// - Starts ignored while busy or done
// - Busy and done overlap one machine cycle
// - Interrupt needs both enables and priority
// - Result loaded at completion or abort, held through restart
// - Channel writable only when idle and clear
// - Start write loads channel, clear write doesnt
// - Channel codes select pins three to six
// - Clock select: CPU or RC, idle only
// - Enable cannot clear while busy or done
// - Successive approximation gives rounded ratiometric code
// - CPU clock conversion lasts 31 machine cycles
// - Power-down aborts CPU-clocked conversion silently
module adcc_top #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic [DATA_W-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [DATA_W-1:0] bus_rdata,
	input wire logic [7:0] port0_pins,
	output logic [7:0] port0_read,
	output logic [7:0] port0_input_off,
	input wire logic rc_tick,
	input wire logic cmp_above,
	output logic [7:0] dac_code,
	output logic [3:0] channel_onehot,
	output logic converter_power_on,
	input wire logic power_down,
	input wire logic global_irq_enable,
	input wire logic irq_is_highest,
	output logic adc_irq_req
);

	adcc_pkg::adcc_ctrl_t ctrl;
	adcc_pkg::adcc_ctrl_t next_ctrl;
	adcc_pkg::adcc_state_t state;
	adcc_pkg::adcc_state_t next_state;
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic [2:0] mc_cnt;
	logic [2:0] next_mc_cnt;
	logic [7:0] trial;
	logic [7:0] next_trial;
	logic [7:0] mask;
	logic [7:0] next_mask;
	logic [7:0] result;
	logic [7:0] next_result;
	logic [7:0] pin_off;
	logic [7:0] next_pin_off;
	logic irq_en;
	logic next_irq_en;
	logic [7:0] next_port0_read;
	logic [3:0] next_onehot;
	logic [DATA_W-1:0] next_rdata;

	logic locked;
	logic wr_ctrl;
	logic start_ok;
	logic abort;
	logic mc_end;
	logic cv_tick;
	logic [7:0] period;
	logic [7:0] ctrl_rd;

	// Shared decode terms
	assign locked = ctrl.busy | ctrl.flag;
	assign wr_ctrl = bus_wr && (bus_addr == ADDR_W'(adcc_pkg::CTRL_ADDR));
	assign mc_end = (mc_cnt == adcc_pkg::MC_LAST);
	assign cv_tick = ctrl.rc ? rc_tick : 1'b1;
	assign period = ctrl.rc ? adcc_pkg::RC_PERIOD : adcc_pkg::CPU_PERIOD;
	assign abort = power_down && ctrl.busy && !ctrl.rc;

	assign start_ok = wr_ctrl && bus_wdata[adcc_pkg::BUSY_BIT] && !locked
		&& (ctrl.en || bus_wdata[adcc_pkg::EN_BIT]) && (state == adcc_pkg::ST_IDLE);

	// control read layout, reserved bits read zero
	assign ctrl_rd = {ctrl.en, 2'b00, ctrl.flag, ctrl.busy, ctrl.rc, ctrl.ch};

	// Machine cycle phase, free running so the RC sync sees real boundaries
	always_comb begin
		next_mc_cnt = mc_end ? 3'h0 : mc_cnt + 3'h1;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mc_cnt <= 3'h0;
		end else if (ce) begin
			mc_cnt <= next_mc_cnt;
		end
	end

	// Control register and conversion sequencer
	always_comb begin
		next_ctrl = ctrl;
		next_state = state;
		next_cnt = cnt;
		next_trial = trial;
		next_mask = mask;
		next_result = result;

		if (wr_ctrl) begin
			next_ctrl.en = bus_wdata[adcc_pkg::EN_BIT] | (locked & ctrl.en);
			// software may only clear the flag
			next_ctrl.flag = ctrl.flag & bus_wdata[adcc_pkg::FLAG_BIT];
			// channel and clock locked while busy or done
			if (!locked) begin
				// same write loads channel with start
				next_ctrl.ch = bus_wdata[adcc_pkg::CH_HI:adcc_pkg::CH_LO];
				next_ctrl.rc = bus_wdata[adcc_pkg::RC_BIT];
			end
		end

		case (state)
			adcc_pkg::ST_IDLE: begin
				if (start_ok) begin
					next_ctrl.busy = 1'b1;
					next_cnt = 8'h00;
					next_trial = 8'h00;
					next_mask = 8'h00;
					next_state = next_ctrl.rc ? adcc_pkg::ST_SYNC : adcc_pkg::ST_SAMP;
				end
			end
			adcc_pkg::ST_SYNC: begin
				// RC mode spends three to four machine cycles aligning
				if (mc_end) begin
					if (cnt == adcc_pkg::SYNC_EDGES - 8'h01) begin
						next_cnt = 8'h00;
						next_state = adcc_pkg::ST_SAMP;
					end else begin
						next_cnt = cnt + 8'h01;
					end
				end
			end
			adcc_pkg::ST_SAMP: begin
				// sample period is the first of nine
				if (cv_tick) begin
					if (cnt == period - 8'h01) begin
						next_cnt = 8'h00;
						next_trial = adcc_pkg::SAR_MSB;
						next_mask = adcc_pkg::SAR_MSB;
						next_state = adcc_pkg::ST_CONV;
					end else begin
						next_cnt = cnt + 8'h01;
					end
				end
			end
			adcc_pkg::ST_CONV: begin
				if (cv_tick) begin
					if (cnt == period - 8'h01) begin
						next_cnt = 8'h00;
						next_trial = (cmp_above ? trial : (trial & ~mask)) | (mask >> 1);
						next_mask = mask >> 1;
						if (mask == adcc_pkg::SAR_LSB) begin
							next_result = cmp_above ? trial : (trial & ~mask);
							// hardware sets flag, wins over clear
							next_ctrl.flag = 1'b1;
							next_state = adcc_pkg::ST_DONE;
						end
					end else begin
						next_cnt = cnt + 8'h01;
					end
				end
			end
			adcc_pkg::ST_DONE: begin
				// busy overlaps flag one machine cycle
				if (cnt == adcc_pkg::DONE_CLKS - 8'h01) begin
					next_cnt = 8'h00;
					next_ctrl.busy = 1'b0;
					next_state = adcc_pkg::ST_IDLE;
				end else begin
					next_cnt = cnt + 8'h01;
				end
			end
			default: begin
				next_ctrl.busy = 1'b0;
				next_cnt = 8'h00;
				next_state = adcc_pkg::ST_IDLE;
			end
		endcase

		// abort leaves partial code, no flag
		if (abort) begin
			next_ctrl.busy = 1'b0;
			next_cnt = 8'h00;
			next_result = trial;
			next_state = adcc_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= adcc_pkg::adcc_ctrl_t'(adcc_pkg::CTRL_RESET[5:0]);
			state <= adcc_pkg::ST_IDLE;
			cnt <= 8'h00;
			trial <= 8'h00;
			mask <= 8'h00;
			result <= adcc_pkg::RESULT_RESET;
		end else if (ce) begin
			ctrl <= next_ctrl;
			state <= next_state;
			cnt <= next_cnt;
			trial <= next_trial;
			mask <= next_mask;
			result <= next_result;
		end
	end

	// Pin gating and interrupt enable registers
	always_comb begin
		next_pin_off = pin_off;
		next_irq_en = irq_en;
		if (bus_wr && (bus_addr == ADDR_W'(adcc_pkg::PIN_OFF_ADDR))) begin
			next_pin_off = bus_wdata[7:0];
		end
		if (bus_wr && (bus_addr == ADDR_W'(adcc_pkg::IRQ_EN_ADDR))) begin
			next_irq_en = bus_wdata[adcc_pkg::IRQ_EN_BIT];
		end
		next_port0_read = port0_pins & ~next_pin_off;
		// channel code to pin three plus code
		next_onehot = 4'h0;
		next_onehot[next_ctrl.ch] = 1'b1;
	end

	// Port read is registered, so a pin change shows one cycle later
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pin_off <= adcc_pkg::PIN_OFF_RESET;
			irq_en <= 1'b0;
			port0_read <= 8'h00;
			channel_onehot <= 4'h1;
		end else if (ce) begin
			pin_off <= next_pin_off;
			irq_en <= next_irq_en;
			port0_read <= next_port0_read;
			channel_onehot <= next_onehot;
		end
	end

	// Read mux; result write falls through with no effect
	always_comb begin
		next_rdata = DATA_W'(adcc_pkg::RDATA_IDLE);
		if (bus_rd) begin
			case (bus_addr)
				ADDR_W'(adcc_pkg::CTRL_ADDR): begin
					next_rdata = DATA_W'(ctrl_rd);
				end
				ADDR_W'(adcc_pkg::PIN_OFF_ADDR): begin
					next_rdata = DATA_W'(pin_off);
				end
				ADDR_W'(adcc_pkg::RESULT_ADDR): begin
					next_rdata = DATA_W'(result);
				end
				ADDR_W'(adcc_pkg::IRQ_EN_ADDR): begin
					next_rdata = DATA_W'({6'h00, irq_en, 1'b0});
				end
				default: begin
					next_rdata = DATA_W'(adcc_pkg::RDATA_IDLE);
				end
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= DATA_W'(adcc_pkg::RDATA_IDLE);
		end else if (ce) begin
			bus_rdata <= next_rdata;
		end
	end

	// Analog side drives straight from registers
	assign dac_code = trial;
	assign port0_input_off = pin_off;
	assign converter_power_on = ctrl.en;

	// request needs flag, both enables, priority
	assign adc_irq_req = ctrl.flag && irq_en && global_irq_enable && irq_is_highest;

endmodule
`default_nettype wire

// [adcc_pkg.sv]
// Shared constants and types for the converter control block
package adcc_pkg;

	// Register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'hc0;
	localparam logic [7:0] PIN_OFF_ADDR = 8'hf6;
	localparam logic [7:0] RESULT_ADDR = 8'hc5;
	localparam logic [7:0] IRQ_EN_ADDR = 8'he8;

	// Field positions
	localparam int EN_BIT = 7;
	localparam int FLAG_BIT = 4;
	localparam int BUSY_BIT = 3;
	localparam int RC_BIT = 2;
	localparam int CH_HI = 1;
	localparam int CH_LO = 0;
	localparam int IRQ_EN_BIT = 1;
	localparam int AIN_BASE_PIN = 3;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PIN_OFF_RESET = 8'h00;
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;

	// Timing
	localparam int MCLK_HZ = 20_000_000;
	localparam int CLKS_PER_MC = 6;
	localparam int CONV_MC = 31;
	localparam int SAR_PERIODS = 9;
	localparam int SETTLE_US = 10;
	localparam int SETTLE_CLKS = (SETTLE_US * MCLK_HZ + 999_999) / 1_000_000;
	localparam int SYNC_MC = 3;
	localparam int RC_TICKS = 108;
	localparam logic [7:0] CPU_PERIOD = 8'((CONV_MC - 1) * CLKS_PER_MC / SAR_PERIODS);
	localparam logic [7:0] RC_PERIOD = 8'(RC_TICKS / SAR_PERIODS);
	localparam logic [7:0] SYNC_EDGES = 8'(SYNC_MC + 1);
	localparam logic [7:0] DONE_CLKS = 8'(CLKS_PER_MC);
	localparam logic [2:0] MC_LAST = 3'(CLKS_PER_MC - 1);
	localparam logic [7:0] SAR_MSB = 8'h80;
	localparam logic [7:0] SAR_LSB = 8'h01;

	// Sequencer states, Gray on each step from idle via sync to done
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SYNC = 3'h1,
		ST_SAMP = 3'h3,
		ST_CONV = 3'h2,
		ST_DONE = 3'h6
	} adcc_state_t;

	// Control register fields
	typedef struct packed {
		logic en;
		logic flag;
		logic busy;
		logic rc;
		logic [1:0] ch;
	} adcc_ctrl_t;

endpackage

// [adcc_top_chk.sv]
// Port-level assertions for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_top_chk (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] port0_pins,
	input wire logic [7:0] port0_read,
	input wire logic [7:0] port0_input_off,
	input wire logic [3:0] channel_onehot,
	input wire logic converter_power_on,
	input wire logic global_irq_enable,
	input wire logic irq_is_highest,
	input wire logic adc_irq_req
);
	// One clock domain, so one clocking and one reset for all
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_pin_gating: assert property ($past(arst_n) |->
		port0_read == ($past(port0_pins) & ~port0_input_off)) else $error("pin read not gated");
	a_irq_gates: assert property (adc_irq_req |-> global_irq_enable && irq_is_highest)
		else $error("irq without enables");
	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data outside read slot");
	a_ctrl_reserved: assert property ($past(bus_rd && bus_addr == adcc_pkg::CTRL_ADDR) |->
		bus_rdata[6:5] == 2'h0) else $error("reserved bits read one");
	a_enable_held: assert property ($past(bus_rd && bus_addr == adcc_pkg::CTRL_ADDR) &&
		(bus_rdata[4] || bus_rdata[3]) |-> bus_rdata[7]) else $error("enable low while active");
	a_chan_onehot: assert property ($onehot(channel_onehot))
		else $error("channel select not one-hot");
	a_chan_cause: assert property (!$stable(channel_onehot) |->
		$past(bus_wr && bus_addr == adcc_pkg::CTRL_ADDR)) else $error("channel moved alone");
	a_power_fall: assert property ($fell(converter_power_on) |->
		$past(bus_wr && bus_addr == adcc_pkg::CTRL_ADDR && !bus_wdata[7]))
		else $error("enable fell without write");
	a_irq_clear: assert property ($fell(adc_irq_req) |->
		!global_irq_enable || !irq_is_highest || $past(bus_wr)) else $error("flag cleared alone");
endmodule
bind adcc_top adcc_top_chk chk (.mclk(mclk), .arst_n(arst_n), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
	.port0_pins(port0_pins), .port0_read(port0_read), .port0_input_off(port0_input_off),
	.channel_onehot(channel_onehot), .converter_power_on(converter_power_on),
	.global_irq_enable(global_irq_enable), .irq_is_highest(irq_is_highest),
	.adc_irq_req(adc_irq_req));
`default_nettype wire

// [adcc_analog_model.sv]
// Analog side model: channel levels, ideal comparator and RC tick source
`timescale 1ns/1ns
`default_nettype none
module adcc_analog_model #(
	parameter logic [31:0] LEVELS = 32'hff_a7_5a_3c
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] dac_code,
	input wire logic [3:0] channel_onehot,
	output logic cmp_above,
	output logic rc_tick
);
	logic [7:0] level;
	logic [1:0] div;
	always_comb begin
		level = 8'h00;
		for (int k = 0; k < 4; k++) begin
			if (channel_onehot[k]) begin
				level = LEVELS[8*k +: 8];
			end
		end
	end
	// ideal comparator; rounding offset is folded into the levels
	assign cmp_above = level >= dac_code;
	// Oscillator runs free, as on chip, at a third of mclk
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div <= 2'h0;
		end else begin
			div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
		end
	end
	assign rc_tick = div == 2'h2;
endmodule
`default_nettype wire

// [adcc_top_test.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcc_top_test;
	localparam logic [31:0] LV = 32'hff_a7_5a_3c;
	localparam logic [7:0] C = adcc_pkg::CTRL_ADDR;
	localparam logic [7:0] R = adcc_pkg::RESULT_ADDR;
	logic mclk, arst_n, bus_wr, bus_rd, power_down, global_irq_enable, irq_is_highest;
	logic [7:0] bus_addr, bus_wdata, bus_rdata, port0_pins, port0_read, port0_input_off, dac_code;
	logic [3:0] channel_onehot;
	logic converter_power_on, adc_irq_req, rc_tick, cmp_above;
	int miscompares = 0;
	int num_checks = 0;
	int n;
	time t0;
	logic ce;
	// Clock enable driven so that one scenario can show a frozen write
	adcc_top DUT (.mclk(mclk), .arst_n(arst_n), .ce(ce), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.port0_pins(port0_pins), .port0_read(port0_read), .port0_input_off(port0_input_off),
		.rc_tick(rc_tick), .cmp_above(cmp_above), .dac_code(dac_code),
		.channel_onehot(channel_onehot), .converter_power_on(converter_power_on),
		.power_down(power_down), .global_irq_enable(global_irq_enable),
		.irq_is_highest(irq_is_highest), .adc_irq_req(adc_irq_req));
	adcc_analog_model #(.LEVELS(LV)) partner (.mclk(mclk), .arst_n(arst_n), .dac_code(dac_code),
		.channel_onehot(channel_onehot), .cmp_above(cmp_above), .rc_tick(rc_tick));
	task automatic end_of_test();
		if (miscompares == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus cycles: one-cycle strobes launched right after an edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1 chk("bus_rdata", e, bus_rdata);
	endtask
	// Bounded wait; n is the edge count since the start write
	task automatic wait_irq(input int lim);
		repeat (lim) begin
			@(posedge mclk);
			#1;
			if (adc_irq_req === 1'b1) break;
		end
		n = int'(($time - t0) / 50);
		// A wait that runs out is a mismatch, not a silent pass
		chk("adc_irq_req", 8'h01, {7'h0, adc_irq_req});
	endtask
	task automatic t_reset();
		rd(C, 8'h00);
		chk("channel_onehot", 8'h01, {4'h0, channel_onehot});
		rd(8'h00, 8'h00);
	endtask
	task automatic t_pins();
		wr(adcc_pkg::PIN_OFF_ADDR, 8'h78);
		@(posedge mclk);
		#1 chk("port0_read", 8'h87, port0_read);
		chk("port0_input_off", 8'h78, port0_input_off);
		// Pins move: only the enabled inputs may follow them
		@(posedge mclk) port0_pins <= 8'h5a;
		@(posedge mclk);
		#1 chk("port0_read", 8'h02, port0_read);
		rd(adcc_pkg::PIN_OFF_ADDR, 8'h78);
		// A write while the clock enable is low must not land
		@(posedge mclk) ce <= 1'b0;
		wr(adcc_pkg::PIN_OFF_ADDR, 8'h00);
		@(posedge mclk) ce <= 1'b1;
		rd(adcc_pkg::PIN_OFF_ADDR, 8'h78);
	endtask
	task automatic t_channels();
		for (int k = 0; k < 4; k++) begin
			wr(C, 8'h80 | 8'(k));
			#1 chk("channel_onehot", 8'h01 << k, {4'h0, channel_onehot});
		end
		repeat (adcc_pkg::SETTLE_CLKS) @(posedge mclk);
	endtask
	task automatic t_cpu_conv();
		wr(adcc_pkg::IRQ_EN_ADDR, 8'h02);
		wr(C, 8'h8a);
		t0 = $time;
		#1 chk("channel_onehot", 8'h04, {4'h0, channel_onehot});
		wait_irq(400);
		chk("conv_cycles", 8'((adcc_pkg::CONV_MC - 1) * adcc_pkg::CLKS_PER_MC), 8'(n));
		rd(C, 8'h9a);
		repeat (8) @(posedge mclk);
		rd(C, 8'h92);
		rd(R, LV[23:16]);
		wr(R, 8'h55);
		rd(R, LV[23:16]);
		rd(adcc_pkg::IRQ_EN_ADDR, 8'h02);
	endtask
	task automatic t_busy_locks();
		// Flag still set: this write only clears it, start and channel ignored
		wr(C, 8'h89);
		rd(C, 8'h82);
		wr(C, 8'h8a);
		wr(C, 8'h02);
		rd(C, 8'h8a);
		wr(C, 8'h8f);
		rd(C, 8'h8a);
		wait_irq(400);
		// Let busy drop so the flag alone blocks the next start
		repeat (8) @(posedge mclk);
		wr(C, 8'h9f);
		rd(C, 8'h92);
		rd(R, LV[23:16]);
		@(posedge mclk) global_irq_enable <= 1'b0;
		#1 chk("adc_irq_req", 8'h00, {7'h0, adc_irq_req});
		@(posedge mclk) global_irq_enable <= 1'b1;
		#1 chk("adc_irq_req", 8'h01, {7'h0, adc_irq_req});
		@(posedge mclk) irq_is_highest <= 1'b0;
		#1 chk("adc_irq_req", 8'h00, {7'h0, adc_irq_req});
		@(posedge mclk) irq_is_highest <= 1'b1;
		wr(C, 8'h83);
		rd(C, 8'h82);
		chk("adc_irq_req", 8'h00, {7'h0, adc_irq_req});
	endtask
	task automatic t_abort();
		wr(C, 8'h89);
		#1 chk("channel_onehot", 8'h02, {4'h0, channel_onehot});
		@(posedge mclk) power_down <= 1'b1;
		@(posedge mclk) power_down <= 1'b0;
		rd(C, 8'h81);
		chk("adc_irq_req", 8'h00, {7'h0, adc_irq_req});
	endtask
	task automatic t_rc_conv();
		wr(C, 8'h84);
		wr(C, 8'h8c);
		t0 = $time;
		// Power-down on the RC clock must not abort the conversion
		@(posedge mclk) power_down <= 1'b1;
		@(posedge mclk) power_down <= 1'b0;
		wait_irq(1000);
		repeat (8) @(posedge mclk);
		rd(C, 8'h94);
		rd(R, LV[7:0]);
		wr(C, 8'h80);
		rd(C, 8'h84);
		wr(C, 8'h00);
		rd(C, 8'h00);
	endtask
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		arst_n = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
		port0_pins = 8'hff;
		power_down = 1'b0;
		global_irq_enable = 1'b1;
		irq_is_highest = 1'b1;
		ce = 1'b1;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_pins();
		t_channels();
		t_cpu_conv();
		t_busy_locks();
		t_abort();
		t_rc_conv();
		end_of_test();
	end
	// Whole run is about 1000 cycles; the limit of 30000 gives it thirty times that
	initial begin
		#1_500_000;
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire
